//--- bench/fdt_asserts.sv
// port checker for the drive timing block
`timescale 1ns/10ps
module fdt_asserts (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        stepPulse,
  input wire logic        headLoad,
  input wire logic        disk_dma_request,
  input wire logic        request_for_master,
  input wire logic        pollActive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // one wait state, always
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_cause: assert property (pready |-> $past(penable))
    else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  // a step pulse is isolated by the spacing timer
  a_step_single: assert property (stepPulse |=> !stepPulse [*8])
    else $error("steps too close");
  a_dma_only: assert property (disk_dma_request |-> !request_for_master)
    else $error("dma and rqm together");
  a_dma_pulse: assert property (disk_dma_request |=> !disk_dma_request)
    else $error("dma request held");
  a_rqm_pulse: assert property (request_for_master |=> !request_for_master)
    else $error("rqm held");
  a_poll_unloaded: assert property (pollActive |-> !headLoad)
    else $error("poll with head loaded");
endmodule // fdt_asserts

//--- bench/fdt_drive_model.sv
// drive mechanism model: head position and track zero sensor
`timescale 1ns/10ps
module fdt_drive_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // step interface
  input  wire logic stepPulse,
  input  wire logic stepDirIn,
  output logic      track_zero_input
);
  int pos;
  // one in, zero out; the head stops hard at track 0
  always @(posedge core_clk) begin
    if (rst) begin
      pos <= 0;
    end else if (stepPulse) begin
      if (stepDirIn) pos <= pos + 1;
      else if (pos > 0) pos <= pos - 1;
    end
  end
  assign track_zero_input = (pos == 0);
endmodule // fdt_drive_model

//--- bench/tb_top.sv
// self-checking bench for the drive timing block
`timescale 1ns/10ps
`include "fdt_defs.vh"
module tb_top;
  logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, stepPulse, stepDirIn, headLoad;
  logic        track_zero_input, disk_dma_request, controller_interrupt;
  logic        request_for_master, pollActive, lastDir;
  logic [3:0]  fifo_threshold_bytes;
  logic [15:0] lf = 16'd392;
  int n_mismatch = 0, checks_done = 0, nStep = 0, nDma = 0, nRqm = 0, i;
  int nInt = 0;
  always #2.5 core_clk = ~core_clk;
  fdt_drive_timing DUT (.core_clk(core_clk), .rst(rst), .clkEn(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .track_zero_input(track_zero_input), .stepPulse(stepPulse),
    .stepDirIn(stepDirIn), .headLoad(headLoad),
    .disk_dma_request(disk_dma_request),
    .controller_interrupt(controller_interrupt),
    .request_for_master(request_for_master), .pollActive(pollActive),
    .fifo_threshold_bytes(fifo_threshold_bytes));
  fdt_drive_model drv (.core_clk(core_clk), .rst(rst), .stepPulse(stepPulse),
    .stepDirIn(stepDirIn), .track_zero_input(track_zero_input));
  // pulse counters for steps and transfer requests
  always @(posedge core_clk) begin
    if (stepPulse) begin nStep <= nStep + 1; lastDir <= stepDirIn; end
    if (disk_dma_request) nDma <= nDma + 1;
    if (request_for_master) nRqm <= nRqm + 1;
    if (controller_interrupt) nInt <= nInt + 1;
  end
  function automatic [15:0] lfsr(input [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is sampled
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) n_mismatch++;
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // poll the busy flag, bounded
  task waitIdle;
    for (int k = 0; k < 40000; k++) begin
      apb(0, `FDT_OFF_STATUS, 0);
      if (rd[`FDT_BUSY_BIT] === 1'b0) break;
      if (k == 39999) n_mismatch++;
    end
  endtask
  task seek(input [31:0] cmd, input [31:0] steps, input dir);
    int s0, i0;
    s0 = nStep;
    i0 = nInt;
    apb(1, `FDT_OFF_COMMAND, cmd);
    waitIdle();
    chk(nStep - s0, steps);
    chk(nInt - i0, 1);
    chk(lastDir, dir);
  endtask
  task xfer(input nd);
    int d0, r0, q0;
    d0 = nDma; r0 = nRqm; q0 = nInt;
    apb(1, `FDT_OFF_TIMING, 32'h0000_01F1 | (nd << `FDT_TMS_BIT));
    apb(1, `FDT_OFF_COMMAND, 32'h0000_0400);
    for (int k = 0; k < 100 && nDma == d0 && nRqm == r0; k++)
      @(posedge core_clk);
    chk(nRqm - r0, nd);
    chk(nDma - d0, !nd);
    chk(nInt - q0, nd);
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (200000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 0;
    apb(0, `FDT_OFF_CONFIG, 0); chk(rd, `FDT_CONFIG_RST);
    apb(0, `FDT_OFF_TIMING, 0); chk(rd, `FDT_TIMING_RST);
    apb(0, `FDT_OFF_VERSION, 0); chk(rd[7:0], `FDT_VERSION_VAL);
    apb(0, 12'h0FC, 0); chk(err, 1'b1);
    chk(nInt, 1);
    $display("test registers done");
    // random thresholds and start tracks, fifo on then off
    for (int n = 0; n < 8; n++) begin
      lf = lfsr(lf);
      apb(1, `FDT_OFF_CONFIG, {16'h0, lf & 16'hFFF1});
      apb(0, `FDT_OFF_CONFIG, 0); chk(rd, {16'h0, lf & 16'hFFF1});
      chk(fifo_threshold_bytes, lf[7:4]);
      apb(1, `FDT_OFF_CONFIG, {16'h0, (lf & 16'hFFF3) | 16'h0002});
      @(negedge core_clk);
      chk(fifo_threshold_bytes, 4'h0);
    end
    $display("test config done");
    // fastest rate and shortest step code keep runs short
    apb(1, `FDT_OFF_TIMING, 32'h0000_01F1);
    seek(32'h0000_0301, 1, 1);
    apb(0, `FDT_OFF_CYL, 0); chk(rd[7:0], 8'h01);
    // one step reaches track zero, the second is refused
    seek(32'h0000_0202, 1, 0);
    apb(0, `FDT_OFF_STATUS, 0); chk(rd[`FDT_EC_BIT], 1'b1);
    apb(0, `FDT_OFF_CYL, 0);
    lf = rd[7:0] + 8'h02;
    seek(32'h0000_0302, 2, 1);
    apb(0, `FDT_OFF_CYL, 0); chk(rd[7:0], lf[7:0]);
    $display("test relative seek done");
    // transfers last: their head settle wait is left running
    xfer(1);
    xfer(0);
    $display("test transfer mode done");
    summarize();
  end
endmodule // tb_top
bind fdt_drive_timing fdt_asserts chk_i (.core_clk(core_clk), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .stepPulse(stepPulse), .headLoad(headLoad),
  .disk_dma_request(disk_dma_request),
  .request_for_master(request_for_master), .pollActive(pollActive));

//--- pkg/fdt_defs.vh
// constants for the floppy drive timing and configuration block
`ifndef FDT_DEFS_VH
`define FDT_DEFS_VH
// apb byte offsets
`define FDT_OFF_TIMING   12'h000
`define FDT_OFF_CONFIG   12'h004
`define FDT_OFF_COMMAND  12'h008
`define FDT_OFF_STATUS   12'h00C
`define FDT_OFF_VERSION  12'h010
`define FDT_OFF_CYL      12'h014
// timing register fields
`define FDT_HUD_LSB      0
`define FDT_SIC_LSB      4
`define FDT_HSD_LSB      8
`define FDT_TMS_BIT      15
`define FDT_RATE_LSB     16
// config register fields
`define FDT_EIS_BIT      0
`define FDT_FDIS_BIT     1
`define FDT_PDIS_BIT     2
`define FDT_THR_LSB      4
`define FDT_PRE_LSB      8
// command register fields
`define FDT_RCN_LSB      0
`define FDT_DIR_BIT      8
`define FDT_GO_BIT       9
`define FDT_XFER_BIT     10
`define FDT_DONE_BIT     11
`define FDT_HLOAD_BIT    12
// status register fields
`define FDT_BUSY_BIT     0
`define FDT_EC_BIT       4
`define FDT_SE_BIT       5
// reset values
`define FDT_TIMING_RST   32'h0000_0000
`define FDT_CONFIG_RST   32'h0000_0002
// version answer, value arbitrary
`define FDT_VERSION_VAL  8'hA5
// timing base: 1 ms at 200 MHz, in a 500 kbps half unit
`define FDT_CLK_MHZ      200
`define FDT_BASE_US      1000
`define FDT_STEP_PULSE   16'h0064
`endif

//--- src/fdt_drive_timing.v
// drive timing, configuration and relative seek engine over apb
// ****************************************
// programming model
// ****************************************
// timing word:
//   [3:0]   unload code, 16 ms a step at 500k, zero is 256 ms
//   [7:4]   step code, 16 ms at zero down to 1 ms at fifteen
//   [14:8]  settle code, 2 ms a step at 500k, zero is 256 ms
//   [15]    one selects non-dma transfers
//   [18:16] data rate, 0 fastest, 4 slowest
// config word:
//   [0]     seek on its own before a transfer
//   [1]     one bypasses the fifo (reset value)
//   [2]     one stops the drive poll after reset
//   [7:4]   fifo threshold less one
//   [15:8]  precompensation start track
// command word (write):
//   [7:0]   relative count, or target cylinder for a transfer
//   [8]     direction, one steps inward
//   [9]     start a relative seek
//   [10]    start a transfer
//   [11]    transfer finished, starts the unload timer
// command word (read): steps still to go
// status word:
//   [0]     sequencer busy
//   [4]     stepped out past track zero
//   [5]     seek ended, cleared by reading status
// version word: fixed identity byte
// cylinder word: present cylinder, wraps at 256
//
// ****************************************
// timing notes
// ****************************************
// all delays are counted in core clocks; the half-ms unit at 500k is
// turned into cycles once, when a delay starts, so a rate change in
// the middle of a wait only takes effect on the next wait
// the 300k rate is reached by multiplying, the 250k and faster ones by
// shifting, so the fast rates lose no precision at all
// the 300k rate uses five thirds of the 500k count; the division
// rounds down, which shortens a wait by less than one cycle
// the counters are 32 bits wide so the longest settle wait at the
// slowest rate, about half a second, still fits with room to spare
//
// ****************************************
// limitations
// ****************************************
// only one relative seek is tracked; a start while the sequencer is
// busy is dropped, and software sees that through the busy bit
// the sequencer knows no physical track count: a relative seek that
// runs past 255 wraps the cylinder and software must keep the carry
// stepping out stops at track zero and flags the check bit; the
// remaining count is left in place so software can read how far
// the head fell short
// the drive poll happens once after reset and never again, since
// only one drive is served here
// the transfer request pins pulse for one clock per command; the
// data path that would repeat them per byte lives elsewhere
// the head stays loaded until a finished transfer starts the unload
// timer and that timer runs out; a seek alone never unloads it
// the precompensation track is only held here; no output carries it
//
// ****************************************
// bus timing
// ****************************************
// every access takes one wait state: the access phase is sampled,
// pready rises on the next clock and stands for that clock only
// the write lands at the first access edge, so a following read at
// once sees the new value
`timescale 1ns/10ps
`include "fdt_defs.vh"
module fdt_drive_timing (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  input  wire        clkEn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // drive side
  input  wire        track_zero_input,
  output reg         stepPulse,
  output reg         stepDirIn,
  output reg         headLoad,
  // transfer signalling
  output reg         disk_dma_request,
  output reg         controller_interrupt,
  output reg         request_for_master,
  output reg         pollActive,
  output reg  [3:0]  fifo_threshold_bytes
);

  // ****************************************
  // state encoding
  // ****************************************
  localparam [4:0] ST_IDLE   = 5'b00001;
  localparam [4:0] ST_STEP   = 5'b00010;
  localparam [4:0] ST_WAIT   = 5'b00100;
  localparam [4:0] ST_SETTLE = 5'b01000;
  localparam [4:0] ST_DONE   = 5'b10000;

  // ****************************************
  // registers
  // ****************************************
  reg  [31:0] timing_reg;
  reg  [31:0] config_reg;
  reg  [7:0]  present_cylinder_reg;
  reg  [7:0]  stepsLeft_reg;
  reg  [4:0]  state_reg;
  reg  [31:0] delayCnt_reg;
  reg  [31:0] unloadCnt_reg;
  reg         firstStep_reg;
  reg         equipment_check_flag_reg;
  reg         seekEnd_reg;
  reg         pollDone_reg;
  reg         implied_reg;
  reg  [7:0]  target_reg;

  wire [3:0] head_unload_delay   = timing_reg[`FDT_HUD_LSB +: 4];
  wire [3:0] step_interval_code  = timing_reg[`FDT_SIC_LSB +: 4];
  wire [6:0] head_settle_delay   = timing_reg[`FDT_HSD_LSB +: 7];
  wire       transfer_mode_select = timing_reg[`FDT_TMS_BIT];
  wire [2:0] rateSel             = timing_reg[`FDT_RATE_LSB +: 3];
  wire       implied_seek_enable = config_reg[`FDT_EIS_BIT];
  wire       fifo_disable        = config_reg[`FDT_FDIS_BIT];
  wire       pollDisable         = config_reg[`FDT_PDIS_BIT];
  wire [3:0] fifo_threshold      = config_reg[`FDT_THR_LSB +: 4];
  wire [7:0] precomp_start_track = config_reg[`FDT_PRE_LSB +: 8];

  // ****************************************
  // helpers
  // ****************************************
  // converts half-ms units at 500 kbps into cycles for the chosen rate;
  // rate 0=2M 1=1M 2=500K 3=300K 4=250K
  function [31:0] scaleCycles;
    input [15:0] halfMs;
    input [2:0]  rate;
    reg   [31:0] base;
    begin
      base = {16'h0000, halfMs} * (`FDT_CLK_MHZ * `FDT_BASE_US / 2);
      case (rate)
        3'h0:    scaleCycles = base >> 2;
        3'h1:    scaleCycles = base >> 1;
        3'h3:    scaleCycles = (base * 5) / 3;
        3'h4:    scaleCycles = base << 1;
        default: scaleCycles = base;
      endcase
    end
  endfunction

  // unload delay in half-ms units: zero means 256 ms
  function [15:0] unloadHalfMs;
    input [3:0] code;
    begin
      if (code == 4'h0)
        unloadHalfMs = 16'h0200;
      else
        unloadHalfMs = {7'h00, code, 5'h00};
    end
  endfunction

  wire [15:0] stepHalfMs = {10'h000, (5'h10 - {1'b0, step_interval_code}),
                            1'b0};
  wire [15:0] settleHalfMs = (head_settle_delay == 7'h00) ? 16'h0200 :
                             {7'h00, head_settle_delay, 2'b00};
  wire apbAccess = psel & penable;
  wire cmdWrite  = apbAccess & pwrite & ~pready &
                   (paddr == `FDT_OFF_COMMAND);
  wire startSeek = cmdWrite & pwdata[`FDT_GO_BIT] &
                   (state_reg == ST_IDLE);
  wire startXfer = cmdWrite & pwdata[`FDT_XFER_BIT];

  // ****************************************
  // apb slave: one wait state, then ready
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      timing_reg <= `FDT_TIMING_RST;
      config_reg <= `FDT_CONFIG_RST;
    end else if (clkEn) begin
      pready <= apbAccess & ~pready;
      pslverr <= 1'b0;
      if (apbAccess & ~pready) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `FDT_OFF_TIMING: begin
            if (pwrite) timing_reg <= pwdata & 32'h0007_FFFF;
            else prdata <= timing_reg;
          end
          `FDT_OFF_CONFIG: begin
            if (pwrite) config_reg <= pwdata & 32'h0000_FFF7;
            else prdata <= config_reg;
          end
          `FDT_OFF_COMMAND: prdata <= {24'h000000, stepsLeft_reg};
          `FDT_OFF_STATUS: prdata <= {26'h0000000, seekEnd_reg,
                                      equipment_check_flag_reg, 3'b000,
                                      ~state_reg[0]};
          `FDT_OFF_VERSION: prdata <= {24'h000000,
                                       `FDT_VERSION_VAL};
          `FDT_OFF_CYL: prdata <= {24'h000000, present_cylinder_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************
  // seek sequencer and head load
  // ****************************************
  // steps are counted, never compared with the cylinder, so a relative
  // seek may run into the wrapped area above 255
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      stepsLeft_reg <= 8'h00;
      delayCnt_reg <= 32'h0000_0000;
      present_cylinder_reg <= 8'h00;
      firstStep_reg <= 1'b0;
      equipment_check_flag_reg <= 1'b0;
      seekEnd_reg <= 1'b0;
      implied_reg <= 1'b0;
      target_reg <= 8'h00;
      stepPulse <= 1'b0;
      stepDirIn <= 1'b0;
      headLoad <= 1'b0;
    end else if (clkEn) begin
      stepPulse <= 1'b0;
      if (apbAccess & ~pready & ~pwrite & (paddr == `FDT_OFF_STATUS))
        seekEnd_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (startSeek) begin
            stepsLeft_reg <= pwdata[`FDT_RCN_LSB +: 8];
            stepDirIn <= pwdata[`FDT_DIR_BIT];
            equipment_check_flag_reg <= 1'b0;
            implied_reg <= 1'b0;
            firstStep_reg <= 1'b1;
            state_reg <= ST_STEP;
          end else if (startXfer) begin
            // target held as cylinder, seek by difference
            target_reg <= pwdata[`FDT_RCN_LSB +: 8];
            if (implied_seek_enable &&
                pwdata[`FDT_RCN_LSB +: 8] != present_cylinder_reg) begin
              implied_reg <= 1'b1;
              stepDirIn <= pwdata[`FDT_RCN_LSB +: 8] >
                           present_cylinder_reg;
              stepsLeft_reg <= (pwdata[`FDT_RCN_LSB +: 8] >
                                present_cylinder_reg) ?
                   pwdata[`FDT_RCN_LSB +: 8] - present_cylinder_reg :
                   present_cylinder_reg - pwdata[`FDT_RCN_LSB +: 8];
              firstStep_reg <= 1'b1;
              state_reg <= ST_STEP;
            end else begin
              headLoad <= 1'b1;
              delayCnt_reg <= scaleCycles(settleHalfMs, rateSel);
              state_reg <= ST_SETTLE;
            end
          end
        end
        ST_STEP: begin
          if (stepsLeft_reg == 8'h00) begin
            state_reg <= ST_DONE;
          end else if (!stepDirIn && track_zero_input) begin
            equipment_check_flag_reg <= 1'b1;
            state_reg <= ST_DONE;
          end else begin
            stepPulse <= 1'b1;
            stepsLeft_reg <= stepsLeft_reg - 8'h01;
            present_cylinder_reg <= stepDirIn ?
              present_cylinder_reg + 8'h01 :
              present_cylinder_reg - 8'h01;
            // first gap halved to start sooner
            delayCnt_reg <= firstStep_reg ?
              (scaleCycles(stepHalfMs, rateSel) >> 1) :
              scaleCycles(stepHalfMs, rateSel);
            firstStep_reg <= 1'b0;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (delayCnt_reg <= 32'h0000_0001)
            state_reg <= ST_STEP;
          else
            delayCnt_reg <= delayCnt_reg - 32'h0000_0001;
        end
        ST_SETTLE: begin
          if (delayCnt_reg <= 32'h0000_0001)
            state_reg <= ST_IDLE;
          else
            delayCnt_reg <= delayCnt_reg - 32'h0000_0001;
        end
        ST_DONE: begin
          if (implied_reg) begin
            implied_reg <= 1'b0;
            headLoad <= 1'b1;
            delayCnt_reg <= scaleCycles(settleHalfMs, rateSel);
            state_reg <= ST_SETTLE;
          end else begin
            seekEnd_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (unloadCnt_reg == 32'h0000_0001)
        headLoad <= 1'b0;
    end
  end

  // ****************************************
  // head unload timer, polling and transfers
  // ****************************************
  // a done write reloads the unload timer; polling waits on it
  always @(posedge core_clk) begin
    if (rst) begin
      unloadCnt_reg <= 32'h0000_0000;
      pollDone_reg <= 1'b0;
      pollActive <= 1'b0;
      disk_dma_request <= 1'b0;
      controller_interrupt <= 1'b0;
      request_for_master <= 1'b0;
      fifo_threshold_bytes <= 4'h0;
    end else if (clkEn) begin
      if (cmdWrite & pwdata[`FDT_DONE_BIT])
        unloadCnt_reg <= scaleCycles(unloadHalfMs(head_unload_delay),
                                     rateSel);
      else if (unloadCnt_reg != 32'h0000_0000)
        unloadCnt_reg <= unloadCnt_reg - 32'h0000_0001;
      pollActive <= ~pollDisable & ~pollDone_reg &
                    ~(headLoad & (unloadCnt_reg != 32'h0000_0000)) &
                    (state_reg == ST_IDLE);
      if (pollActive)
        pollDone_reg <= 1'b1;
      // fifo off means a request per byte; otherwise the field goes out unchanged
      fifo_threshold_bytes <= fifo_disable ? 4'h0 :
                              fifo_threshold;
      disk_dma_request <= startXfer & ~transfer_mode_select;
      request_for_master <= startXfer & transfer_mode_select;
      controller_interrupt <= (startXfer & transfer_mode_select) |
                              (state_reg == ST_DONE & ~implied_reg) |
                              (pollActive & ~pollDone_reg);
    end
  end

  // precompensation track is held for the write path
  wire unusedPre = |precomp_start_track | |target_reg;

endmodule // fdt_drive_timing
